// ===== pkh_host.sv
`timescale 1ns/1ps
module pkh_host
  import pkh_pkg::*;
#(
  parameter int REPLY_CYC = REPLY_CYC_DEF
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic ps2_data_i,
  output logic ps2_clk_o,
  output logic ps2_clk_oe_o,
  output logic ps2_data_o,
  output logic ps2_data_oe_o,
  input wire logic mouse_mode_i,
  input wire logic tx_enable_i,
  input wire logic cmd_valid_i,
  input wire pkh_cmd_t cmd_i,
  input wire logic [7:0] cmd_arg_i,
  output logic cmd_busy_o,
  output logic cmd_done_o,
  output logic cmd_err_o,
  output logic key_valid_o,
  output pkh_key_t key_o,
  output logic mouse_valid_o,
  output pkh_mouse_t mouse_o,
  output logic frame_err_o
);
  localparam logic [TIMER_W-1:0] REPLY_LAST = TIMER_W'(REPLY_CYC - 1);

  typedef struct packed {
    logic clk_m;
    logic clk_s;
    logic dat_m;
    logic dat_s;
    logic tog_m;
    logic tog_s;
    logic tog_prev;
    logic rx_hold;
    logic break_pend;
    logic ext_pend;
    pkh_key_t key;
    logic key_valid;
    logic [1:0] midx;
    logic [7:0] mstat;
    logic [7:0] mx;
    pkh_mouse_t mouse;
    logic mouse_valid;
    logic frame_err;
    pkh_cstate_t cstate;
    pkh_cmd_t cmd;
    logic [7:0] arg;
    logic tx_start;
    logic [7:0] tx_byte;
    logic [TIMER_W-1:0] timer;
    logic cmd_busy;
    logic cmd_done;
    logic cmd_err;
  } pkh_host_st_t;

  pkh_host_st_t s;
  pkh_host_st_t next_s;
  pkh_frame_t rx_frame;
  logic rx_toggle;
  logic rx_rst;
  logic tx_busy;
  logic tx_done;
  logic tx_nack;
  logic tx_clk_oe;
  logic tx_data_oe;
  logic frame_new;
  logic frame_good;
  logic [7:0] rx_byte;

  // Half frames seen while the host owns the link are discarded
  assign rx_rst = rst_i | s.rx_hold;

  // Receiver runs on the peripheral clock itself
  pkh_rx u_rx (
    .link_clk_i(link_clk_i),
    .rst_i(rx_rst),
    .data_i(ps2_data_i),
    .frame_o(rx_frame),
    .toggle_o(rx_toggle)
  );

  pkh_tx u_tx (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .start_i(s.tx_start),
    .byte_i(s.tx_byte),
    .clk_s_i(s.clk_s),
    .data_s_i(s.dat_s),
    .busy_o(tx_busy),
    .done_o(tx_done),
    .nack_o(tx_nack),
    .clk_oe_o(tx_clk_oe),
    .data_oe_o(tx_data_oe)
  );

  // Frame word is stable for eleven link clocks after its toggle moves
  assign frame_new = s.tog_s ^ s.tog_prev;
  assign frame_good = pkh_frame_ok(rx_frame);
  assign rx_byte = rx_frame[BIT_DATA_LSB +: 8];

  always_comb begin
    next_s = s;
    // Synchronisers for the link pins and the frame toggle
    next_s.clk_m = link_clk_i;
    next_s.clk_s = s.clk_m;
    next_s.dat_m = ps2_data_i;
    next_s.dat_s = s.dat_m;
    next_s.tog_m = rx_toggle;
    next_s.tog_s = s.tog_m;
    next_s.tog_prev = s.tog_s;
    next_s.rx_hold = tx_busy;
    next_s.key_valid = 1'b0;
    next_s.mouse_valid = 1'b0;
    next_s.frame_err = 1'b0;
    next_s.tx_start = 1'b0;
    next_s.cmd_done = 1'b0;
    next_s.cmd_err = 1'b0;

    // Incoming traffic outside a command exchange
    if (frame_new && s.cstate == C_IDLE) begin
      if (!frame_good) begin
        next_s.frame_err = 1'b1;
        next_s.midx = '0;
        next_s.break_pend = 1'b0;
        next_s.ext_pend = 1'b0;
      end else if (mouse_mode_i) begin
        next_s.midx = (s.midx == MOUSE_LAST) ? 2'h0 : s.midx + 2'h1;
        unique case (s.midx)
          2'h0: next_s.mstat = rx_byte;
          2'h1: next_s.mx = rx_byte;
          default: begin
            next_s.mouse.x = {s.mstat[ST_XSIGN], s.mx};
            next_s.mouse.y = {s.mstat[ST_YSIGN], rx_byte};
            next_s.mouse.x_overflow_bit = s.mstat[ST_XOVF];
            next_s.mouse.y_overflow_bit = s.mstat[ST_YOVF];
            next_s.mouse.left = s.mstat[ST_LEFT];
            next_s.mouse.right = s.mstat[ST_RIGHT];
            next_s.mouse_valid = 1'b1;
          end
        endcase
      end else if (rx_byte == KEY_UP_CODE) begin
        next_s.break_pend = 1'b1;
      end else if (rx_byte == EXTEND_CODE) begin
        next_s.ext_pend = 1'b1;
      end else begin
        // Raw code out; shift and character mapping belong downstream
        next_s.key = '{code: rx_byte, key_up: s.break_pend, extended: s.ext_pend};
        next_s.key_valid = 1'b1;
        next_s.break_pend = 1'b0;
        next_s.ext_pend = 1'b0;
      end
    end

    // Command exchange with the keyboard
    unique case (s.cstate)
      C_IDLE: begin
        if (cmd_valid_i && tx_enable_i) begin
          next_s.cmd = cmd_i;
          next_s.arg = cmd_arg_i;
          next_s.tx_byte = pkh_opcode(cmd_i);
          next_s.tx_start = 1'b1;
          next_s.cmd_busy = 1'b1;
          next_s.cstate = C_SEND;
        end
      end
      C_SEND: begin
        next_s.timer = '0;
        if (tx_done) begin
          if (tx_nack) begin
            next_s.cmd_err = 1'b1;
            next_s.cmd_busy = 1'b0;
            next_s.cstate = C_IDLE;
          end else if (s.cmd == PKH_RESEND || s.cmd == PKH_RESET) begin
            // Reply to these is ordinary traffic, decoded as usual
            next_s.cmd_done = 1'b1;
            next_s.cmd_busy = 1'b0;
            next_s.cstate = C_IDLE;
          end else begin
            next_s.cstate = C_REPLY;
          end
        end
      end
      C_REPLY: begin
        next_s.timer = s.timer + 1'b1;
        if (frame_new) begin
          if (frame_good && s.cmd == PKH_ECHO && rx_byte == OP_ECHO) begin
            next_s.cmd_done = 1'b1;
            next_s.cmd_busy = 1'b0;
            next_s.cstate = C_IDLE;
          end else if (frame_good && s.cmd != PKH_ECHO && rx_byte == ACK_CODE) begin
            next_s.tx_byte = s.arg;
            next_s.tx_start = 1'b1;
            next_s.cstate = C_ARG;
          end else begin
            next_s.cmd_err = 1'b1;
            next_s.cmd_busy = 1'b0;
            next_s.cstate = C_IDLE;
          end
        end else if (s.timer == REPLY_LAST) begin
          // Silent keyboard must not hang the command port
          next_s.cmd_err = 1'b1;
          next_s.cmd_busy = 1'b0;
          next_s.cstate = C_IDLE;
        end
      end
      C_ARG: begin
        next_s.timer = '0;
        if (tx_done) begin
          if (tx_nack) begin
            next_s.cmd_err = 1'b1;
            next_s.cmd_busy = 1'b0;
            next_s.cstate = C_IDLE;
          end else begin
            next_s.cstate = C_ARG_ACK;
          end
        end
      end
      C_ARG_ACK: begin
        next_s.timer = s.timer + 1'b1;
        if (frame_new || s.timer == REPLY_LAST) begin
          next_s.cmd_done = frame_new && frame_good && rx_byte == ACK_CODE;
          next_s.cmd_err = !(frame_new && frame_good && rx_byte == ACK_CODE);
          next_s.cmd_busy = 1'b0;
          next_s.cstate = C_IDLE;
        end
      end
      default: begin
        next_s.cmd_busy = 1'b0;
        next_s.cstate = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Lines are only ever pulled low; the enable decides whether we pull
  assign ps2_clk_o = 1'b0;
  assign ps2_data_o = 1'b0;
  assign ps2_clk_oe_o = tx_clk_oe;
  assign ps2_data_oe_o = tx_data_oe;
  assign cmd_busy_o = s.cmd_busy;
  assign cmd_done_o = s.cmd_done;
  assign cmd_err_o = s.cmd_err;
  assign key_valid_o = s.key_valid;
  assign key_o = s.key;
  assign mouse_valid_o = s.mouse_valid;
  assign mouse_o = s.mouse;
  assign frame_err_o = s.frame_err;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  chk_no_drive_idle: assert property (
    (s.cstate == C_IDLE) && !tx_enable_i && !tx_busy |=> !s.tx_start ##1 !ps2_clk_oe_o && !ps2_data_oe_o)
    else $error("host drove the link while sending disabled");
  chk_bad_frame_flag: assert property (
    frame_new && !frame_good && (s.cstate == C_IDLE) |=> frame_err_o && !key_valid_o && !mouse_valid_o)
    else $error("bad frame not flagged");
  chk_break_prefix: assert property (
    frame_new && frame_good && !mouse_mode_i && (s.cstate == C_IDLE) && (rx_byte == KEY_UP_CODE)
    |=> s.break_pend && !key_valid_o)
    else $error("key-up prefix not remembered");
  chk_mouse_sign: assert property (
    mouse_valid_o |-> (mouse_o.x[8] == s.mstat[ST_XSIGN]) && (mouse_o.y[8] == s.mstat[ST_YSIGN])
      && (mouse_o.x[7:0] == s.mx))
    else $error("mouse sign not taken from status");
  chk_mouse_ovf: assert property (
    mouse_valid_o |-> (mouse_o.x_overflow_bit == s.mstat[ST_XOVF]) && (mouse_o.y_overflow_bit == s.mstat[ST_YOVF]))
    else $error("mouse overflow mismatch");
  chk_mouse_buttons: assert property (
    mouse_valid_o |-> (mouse_o.left == s.mstat[ST_LEFT]) && (mouse_o.right == s.mstat[ST_RIGHT]))
    else $error("mouse buttons mismatch");
  chk_mouse_third: assert property (
    mouse_valid_o |-> ($past(s.midx) == MOUSE_LAST) && (s.midx == 2'h0))
    else $error("mouse report not on third word");
  chk_arg_after_ack: assert property (
    (s.cstate == C_REPLY) && frame_new && frame_good && (s.cmd != PKH_ECHO) && (rx_byte == ACK_CODE)
    |=> s.tx_start && (s.tx_byte == s.arg) ##1 tx_busy [*2])
    else $error("argument byte not sent after acknowledge");
  chk_pins_low: assert property (
    !ps2_clk_o && !ps2_data_o)
    else $error("link driven high");
  // Command port: take, replies; raw scan codes; and what a bad frame leaves behind
  chk_cmd_take: assert property (
    (s.cstate == C_IDLE) && cmd_valid_i && tx_enable_i |=> cmd_busy_o && s.tx_start ##1 ps2_clk_oe_o)
    else $error("command not started on the link");
  chk_echo_done: assert property (
    (s.cstate == C_REPLY) && frame_new && frame_good && (s.cmd == PKH_ECHO) && (rx_byte == OP_ECHO)
    |=> cmd_done_o && !cmd_err_o && !cmd_busy_o)
    else $error("echo reply not accepted");
  chk_echo_wrong: assert property (
    (s.cstate == C_REPLY) && frame_new && (s.cmd == PKH_ECHO) && (rx_byte != OP_ECHO)
    |=> cmd_err_o && !cmd_done_o && !cmd_busy_o)
    else $error("wrong echo reply not refused");
  chk_arg_ack_done: assert property (
    (s.cstate == C_ARG_ACK) && frame_new && frame_good && (rx_byte == ACK_CODE)
    |=> cmd_done_o && !cmd_busy_o)
    else $error("argument acknowledge not accepted");
  chk_key_out: assert property (
    frame_new && frame_good && !mouse_mode_i && (s.cstate == C_IDLE) && (rx_byte != KEY_UP_CODE)
    && (rx_byte != EXTEND_CODE) |=> key_valid_o && (key_o.code == $past(rx_byte))
    && (key_o.extended == $past(s.ext_pend)))
    else $error("scan code not passed on raw");
  chk_bad_frame_clear: assert property (
    frame_new && !frame_good && (s.cstate == C_IDLE) |=> !s.break_pend && !s.ext_pend && (s.midx == 2'h0))
    else $error("bad frame left prefixes pending");

  cov_key_release: cover property (key_valid_o && key_o.key_up);
  cov_mouse_report: cover property (mouse_valid_o);
  cov_cmd_done: cover property (cmd_done_o && s.cmd == PKH_LEDS);
  cov_frame_err: cover property (frame_err_o);
  cov_echo_err: cover property (cmd_err_o && s.cmd == PKH_ECHO);
endmodule

// ===== pkh_pkg.sv
package pkh_pkg;
  // Timing, at the 40 MHz reference clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int INHIBIT_NS = 100000;
  localparam int INHIBIT_CYC = (INHIBIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REPLY_MS = 20;
  localparam int REPLY_CYC_DEF = REPLY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TIMER_W = 20;
  localparam int INHIBIT_W = 12;

  // Frame layout, bit 0 is the first bit on the wire
  localparam int FRAME_BITS = 11;
  localparam logic [3:0] LAST_BIT = 4'ha;
  localparam logic [3:0] PARITY_SLOT = 4'h8;
  localparam logic [3:0] STOP_SLOT = 4'h9;
  localparam int BIT_START = 0;
  localparam int BIT_DATA_LSB = 1;
  localparam int BIT_PARITY = 9;
  localparam int BIT_STOP = 10;

  // Link bytes
  localparam logic [7:0] KEY_UP_CODE = 8'hf0;
  localparam logic [7:0] EXTEND_CODE = 8'he0;
  localparam logic [7:0] ACK_CODE = 8'hfa;
  localparam logic [7:0] OP_LEDS = 8'hed;
  localparam logic [7:0] OP_ECHO = 8'hee;
  localparam logic [7:0] OP_RATE = 8'hf3;
  localparam logic [7:0] OP_RESEND = 8'hfe;
  localparam logic [7:0] OP_RESET = 8'hff;

  // Mouse status byte fields
  localparam int ST_LEFT = 0;
  localparam int ST_RIGHT = 1;
  localparam int ST_XSIGN = 4;
  localparam int ST_YSIGN = 5;
  localparam int ST_XOVF = 6;
  localparam int ST_YOVF = 7;
  localparam logic [1:0] MOUSE_LAST = 2'h2;

  typedef logic [FRAME_BITS-1:0] pkh_frame_t;
  typedef enum logic [2:0] {PKH_LEDS, PKH_ECHO, PKH_RATE, PKH_RESEND, PKH_RESET} pkh_cmd_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_INHIBIT = 2'b01, TX_BITS = 2'b11, TX_END = 2'b10} pkh_tx_state_t;
  typedef enum logic [2:0] {
    C_IDLE = 3'b000, C_SEND = 3'b001, C_REPLY = 3'b011, C_ARG = 3'b010, C_ARG_ACK = 3'b110
  } pkh_cstate_t;

  typedef struct packed {
    logic [7:0] code;
    logic key_up;
    logic extended;
  } pkh_key_t;

  typedef struct packed {
    logic signed [8:0] x;
    logic signed [8:0] y;
    logic x_overflow_bit;
    logic y_overflow_bit;
    logic left;
    logic right;
  } pkh_mouse_t;

  // Odd parity bit for a data byte
  function automatic logic pkh_odd_parity(input logic [7:0] b);
    return ~^b;
  endfunction

  // Start low, stop high, odd parity over data and parity
  function automatic logic pkh_frame_ok(input pkh_frame_t f);
    return !f[BIT_START] && f[BIT_STOP] && (^f[BIT_PARITY:BIT_DATA_LSB]);
  endfunction

  function automatic logic [7:0] pkh_opcode(input pkh_cmd_t c);
    case (c)
      PKH_LEDS: return OP_LEDS;
      PKH_ECHO: return OP_ECHO;
      PKH_RATE: return OP_RATE;
      PKH_RESEND: return OP_RESEND;
      default: return OP_RESET;
    endcase
  endfunction
endpackage

// ===== pkh_rx.sv
`timescale 1ns/1ps
module pkh_rx
  import pkh_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic rst_i,
  input wire logic data_i,
  output pkh_frame_t frame_o,
  output logic toggle_o
);
  typedef struct packed {
    logic [3:0] cnt;
    logic [FRAME_BITS-2:0] sh;
    pkh_frame_t frame;
    logic toggle;
  } pkh_rx_st_t;

  pkh_rx_st_t s;
  pkh_rx_st_t next_s;

  // Data is set while the link clock is high, so it is steady at the fall
  always_comb begin
    next_s = s;
    if (s.cnt == LAST_BIT) begin
      next_s.frame = {data_i, s.sh};
      next_s.toggle = ~s.toggle;
      next_s.cnt = '0;
    end else begin
      next_s.sh = {data_i, s.sh[FRAME_BITS-2:1]};
      next_s.cnt = s.cnt + 4'h1;
    end
  end

  // Reset also clears a half frame when the host takes the link
  always_ff @(negedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign frame_o = s.frame;
  assign toggle_o = s.toggle;

  chk_frame_length: assert property (@(negedge link_clk_i) disable iff (rst_i)
    (s.cnt == LAST_BIT) |=> (s.cnt == 4'h0) && (s.toggle != $past(s.toggle)))
    else $error("frame not closed after eleven bits");
endmodule

// ===== pkh_tx.sv
`timescale 1ns/1ps
module pkh_tx
  import pkh_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] byte_i,
  input wire logic clk_s_i,
  input wire logic data_s_i,
  output logic busy_o,
  output logic done_o,
  output logic nack_o,
  output logic clk_oe_o,
  output logic data_oe_o
);
  localparam logic [INHIBIT_W-1:0] INHIBIT_LAST = INHIBIT_W'(INHIBIT_CYC - 1);

  typedef struct packed {
    pkh_tx_state_t state;
    logic [INHIBIT_W-1:0] cnt;
    logic [8:0] sh;
    logic [3:0] nbits;
    logic clk_prev;
    logic busy;
    logic done;
    logic nack;
    logic clk_oe;
    logic data_oe;
  } pkh_tx_st_t;

  pkh_tx_st_t s;
  pkh_tx_st_t next_s;
  logic clk_fall;

  assign clk_fall = s.clk_prev && !clk_s_i;

  // Inhibit, request to send, then one bit per peripheral clock fall
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.clk_prev = clk_s_i;
    unique case (s.state)
      TX_IDLE: begin
        if (start_i) begin
          next_s.state = TX_INHIBIT;
          next_s.cnt = '0;
          next_s.clk_oe = 1'b1;
          next_s.sh = {pkh_odd_parity(byte_i), byte_i};
          next_s.busy = 1'b1;
          next_s.nack = 1'b0;
        end
      end
      TX_INHIBIT: begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == INHIBIT_LAST) begin
          next_s.data_oe = 1'b1; // Start bit laid down before clock release
          next_s.nbits = '0;
          next_s.state = TX_BITS;
        end
      end
      TX_BITS: begin
        next_s.clk_oe = 1'b0;
        if (clk_fall) begin
          next_s.nbits = s.nbits + 4'h1;
          if (s.nbits <= PARITY_SLOT) begin
            next_s.data_oe = ~s.sh[0];
            next_s.sh = {1'b0, s.sh[8:1]};
          end else if (s.nbits == STOP_SLOT) begin
            next_s.data_oe = 1'b0;
          end else begin
            next_s.nack = data_s_i; // Peripheral pulls data low to acknowledge
            next_s.state = TX_END;
          end
        end
      end
      TX_END: begin
        if (clk_s_i && data_s_i) begin
          next_s.state = TX_IDLE;
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy_o = s.busy;
  assign done_o = s.done;
  assign nack_o = s.nack;
  assign clk_oe_o = s.clk_oe;
  assign data_oe_o = s.data_oe;

  chk_inhibit_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (s.state == TX_INHIBIT) |-> s.clk_oe && !s.data_oe)
    else $error("clock not held low during inhibit");
  chk_rts_order: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(s.data_oe) && (s.state == TX_BITS) && ($past(s.state) == TX_INHIBIT) |-> s.clk_oe ##1 !s.clk_oe)
    else $error("clock released before request to send");
endmodule

// ===== pkh_ps2_dev.sv
`timescale 1ns/1ps
// Behavioural keyboard or mouse on the far side of the two-wire port
module pkh_ps2_dev
  import pkh_pkg::*;
(
  input wire logic clk_w_i,
  input wire logic data_w_i,
  input wire logic host_clk_oe_i,
  input wire logic host_data_oe_i,
  output logic clk_pd_o,
  output logic data_pd_o
);
  localparam int FAST_NS = 3; // 6 ns link clock
  localparam int SLOW_NS = 500; // Host bits pass a ref-domain sync, so clock slowly
  logic [7:0] last_sent;
  logic [2:0] leds;
  logic bad_reply;
  logic [7:0] got[$];
  logic [7:0] b;
  logic [7:0] op;

  initial begin
    clk_pd_o = 0;
    data_pd_o = 0;
    last_sent = 0;
    leds = 0;
    bad_reply = 0;
  end

  // One frame to the host, data moves only while the clock is high
  task automatic send_byte(input logic [7:0] v, input logic bad_par);
    logic [10:0] f;
    f = {1'b1, ~^v ^ bad_par, v, 1'b0};
    wait (clk_w_i && data_w_i);
    for (int i = 0; i < 11; i++) begin
      data_pd_o = ~f[i];
      #FAST_NS clk_pd_o = 1;
      #FAST_NS clk_pd_o = 0;
    end
    data_pd_o = 0;
    #400;
  endtask

  task automatic key(input logic [7:0] v);
    last_sent = v;
    send_byte(v, 1'b0);
  endtask

  // Clock in one host byte, sampling at each rise, then pull data low as ack
  task automatic recv(output logic [7:0] v);
    logic [9:0] rx;
    wait (host_data_oe_i && !host_clk_oe_i);
    #SLOW_NS;
    for (int i = 0; i < 10; i++) begin
      clk_pd_o = 1;
      #SLOW_NS clk_pd_o = 0;
      rx[i] = data_w_i;
      #SLOW_NS;
    end
    data_pd_o = 1;
    clk_pd_o = 1;
    #SLOW_NS clk_pd_o = 0;
    #SLOW_NS data_pd_o = 0;
    v = rx[7:0];
    got.push_back(v);
    #2000;
  endtask

  // Command handling on the keyboard side
  always begin
    recv(op);
    case (op)
      OP_LEDS, OP_RATE: begin
        send_byte(ACK_CODE, 1'b0);
        recv(b);
        if (op == OP_LEDS) leds = b[2:0];
        send_byte(ACK_CODE, 1'b0);
      end
      OP_ECHO: send_byte(bad_reply ? 8'h11 : OP_ECHO, 1'b0);
      OP_RESEND: send_byte(last_sent, 1'b0);
      OP_RESET: begin
        last_sent = 0;
        leds = 0;
      end
      default: ;
    endcase
  end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
  import pkh_pkg::*;
  logic ref_clk_i = 0;
  logic rst_i = 0;
  logic mouse_mode_i = 0;
  logic tx_enable_i = 1;
  logic cmd_valid_i = 0;
  pkh_cmd_t cmd_i = PKH_ECHO;
  logic [7:0] cmd_arg_i = 0;
  logic ps2_clk_o, ps2_clk_oe_o, ps2_data_o, ps2_data_oe_o, cmd_busy_o, cmd_done_o, cmd_err_o;
  logic key_valid_o, mouse_valid_o, frame_err_o, clk_pd, data_pd, clk_w, data_w;
  pkh_key_t key_o, last_key;
  pkh_mouse_t mouse_o, last_mouse;
  int miscompares = 0;
  int n_checks = 0;
  int key_cnt = 0, mouse_cnt = 0, ferr_cnt = 0, done_cnt = 0, err_cnt = 0, inh_cyc = 0, oe_cyc = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;
  // Open-drain lines with pull-ups
  assign clk_w = (ps2_clk_oe_o ? ps2_clk_o : 1'b1) & ~clk_pd;
  assign data_w = (ps2_data_oe_o ? ps2_data_o : 1'b1) & ~data_pd;

  pkh_host #(.REPLY_CYC(20000)) DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link_clk_i(clk_w),
    .ps2_data_i(data_w), .ps2_clk_o(ps2_clk_o), .ps2_clk_oe_o(ps2_clk_oe_o), .ps2_data_o(ps2_data_o),
    .ps2_data_oe_o(ps2_data_oe_o), .mouse_mode_i(mouse_mode_i), .tx_enable_i(tx_enable_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_arg_i(cmd_arg_i), .cmd_busy_o(cmd_busy_o),
    .cmd_done_o(cmd_done_o), .cmd_err_o(cmd_err_o), .key_valid_o(key_valid_o), .key_o(key_o),
    .mouse_valid_o(mouse_valid_o), .mouse_o(mouse_o), .frame_err_o(frame_err_o));
  pkh_ps2_dev DEV (.clk_w_i(clk_w), .data_w_i(data_w), .host_clk_oe_i(ps2_clk_oe_o),
    .host_data_oe_i(ps2_data_oe_o), .clk_pd_o(clk_pd), .data_pd_o(data_pd));

  // Catch one-cycle pulses so tests can look at them later
  always @(posedge ref_clk_i) begin
    if (key_valid_o === 1'b1) begin
      key_cnt++;
      last_key = key_o;
    end
    if (mouse_valid_o === 1'b1) begin
      mouse_cnt++;
      last_mouse = mouse_o;
    end
    if (frame_err_o === 1'b1) ferr_cnt++;
    if (cmd_done_o === 1'b1) done_cnt++;
    if (cmd_err_o === 1'b1) err_cnt++;
    if (ps2_clk_oe_o === 1'b1 && ps2_data_oe_o !== 1'b1) inh_cyc++;
    if (ps2_clk_oe_o !== 1'b0 || ps2_data_oe_o !== 1'b0) oe_cyc++;
  end

  task automatic frame(input logic [7:0] v, input logic bad);
    DEV.send_byte(v, bad);
    repeat (10) @(negedge ref_clk_i);
  endtask

  task automatic pulse_cmd(input pkh_cmd_t c, input logic [7:0] a);
    @(negedge ref_clk_i);
    cmd_i = c;
    cmd_arg_i = a;
    cmd_valid_i = 1;
    inh_cyc = 0;
    @(negedge ref_clk_i);
    cmd_valid_i = 0;
  endtask

  // One command, then wait for its verdict pulse
  task automatic command(input pkh_cmd_t c, input logic [7:0] a, input logic ok);
    int d;
    int e;
    d = done_cnt;
    e = err_cnt;
    pulse_cmd(c, a);
    `CHK(cmd_busy_o, 1'b1)
    for (int i = 0; i < 30000 && done_cnt + err_cnt == d + e; i++) @(negedge ref_clk_i);
    `CHK(cmd_busy_o, 1'b0)
    `CHK(done_cnt, d + int'(ok))
    `CHK(err_cnt, e + int'(!ok))
    repeat (200) @(negedge ref_clk_i);
  endtask

  task automatic expect_rx(input logic [7:0] v);
    logic [7:0] h;
    h = DEV.got.size() > 0 ? DEV.got.pop_front() : 8'hxx;
    `CHK(h, v)
  endtask

  task automatic print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    // About twice the length of a clean run
    #(80000 * CLK_PERIOD_NS);
    miscompares++;
    print_verdict;
  end

  initial begin
    // Raise reset after time zero so the link-side receiver sees an edge
    #1 rst_i = 1;
    repeat (5) @(negedge ref_clk_i);
    rst_i = 0;
    repeat (2) @(negedge ref_clk_i);
    // Keyboard make, break and extended codes
    DEV.key(8'h1c);
    repeat (10) @(negedge ref_clk_i);
    `CHK(last_key, pkh_key_t'({8'h1c, 1'b0, 1'b0}))
    DEV.key(8'h1c);
    repeat (10) @(negedge ref_clk_i);
    `CHK(key_cnt, 2)
    frame(KEY_UP_CODE, 0);
    frame(8'h1c, 0);
    `CHK(last_key, pkh_key_t'({8'h1c, 1'b1, 1'b0}))
    `CHK(key_cnt, 3)
    frame(EXTEND_CODE, 0);
    frame(KEY_UP_CODE, 0);
    frame(8'h75, 0);
    `CHK(last_key, pkh_key_t'({8'h75, 1'b1, 1'b1}))
    frame(EXTEND_CODE, 0);
    frame(8'h75, 0);
    `CHK(last_key, pkh_key_t'({8'h75, 1'b0, 1'b1}))
    $display("test keyboard codes finished");
    // Bad parity drops the pending key-up prefix
    frame(KEY_UP_CODE, 0);
    frame(8'h1c, 1);
    `CHK(ferr_cnt, 1)
    frame(8'h1c, 0);
    `CHK(last_key, pkh_key_t'({8'h1c, 1'b0, 1'b0}))
    `CHK(key_cnt, 6)
    $display("test frame error finished");
    // Mouse reports: status, X, Y
    mouse_mode_i = 1;
    frame(8'h91, 0);
    frame(8'hf0, 0);
    `CHK(mouse_cnt, 0)
    frame(8'h05, 0);
    `CHK(last_mouse, pkh_mouse_t'({9'h1f0, 9'h005, 1'b0, 1'b1, 1'b1, 1'b0}))
    frame(8'h62, 0);
    frame(8'h10, 0);
    frame(8'h80, 0);
    `CHK(last_mouse, pkh_mouse_t'({9'h010, 9'h180, 1'b1, 1'b0, 1'b0, 1'b1}))
    `CHK(mouse_cnt, 2)
    mouse_mode_i = 0;
    $display("test mouse reports finished");
    // Sending disabled: pins stay inputs
    tx_enable_i = 0;
    oe_cyc = 0;
    pulse_cmd(PKH_RESET, 8'h00);
    repeat (100) @(negedge ref_clk_i);
    `CHK(oe_cyc, 0)
    `CHK(cmd_busy_o, 1'b0)
    tx_enable_i = 1;
    $display("test input only finished");
    // Every command, with keyboard replies to all but reset
    command(PKH_ECHO, 8'h00, 1);
    `CHK(inh_cyc >= INHIBIT_CYC - 1 && inh_cyc <= INHIBIT_CYC, 1'b1)
    expect_rx(OP_ECHO);
    command(PKH_LEDS, 8'h05, 1);
    expect_rx(OP_LEDS);
    expect_rx(8'h05);
    `CHK(DEV.leds, 3'h5)
    command(PKH_RATE, 8'h2a, 1);
    expect_rx(OP_RATE);
    expect_rx(8'h2a);
    command(PKH_RESEND, 8'h00, 1);
    expect_rx(OP_RESEND);
    `CHK(key_cnt, 7)
    `CHK(last_key.code, 8'h1c)
    command(PKH_RESET, 8'h00, 1);
    expect_rx(OP_RESET);
    $display("test commands finished");
    // Echo answered with the wrong byte
    DEV.bad_reply = 1;
    command(PKH_ECHO, 8'h00, 0);
    expect_rx(OP_ECHO);
    $display("test wrong reply finished");
    print_verdict;
  end
endmodule
